// ---- design/pwc_top.sv ----
// periodic wakeup counter: source select, prescaler, 8-bit modulo counter and registers
//
// How it works
// - 8-bit counter advances per prescaler tick, readable
// - counter at limit wraps to zero, sets flag
// - limit zero sets flag every tick
// - flag bit 7; write one clears it
// - enable bit 4 drives interrupt from flag
// - bits 6-5 pick source clock
// - changed source value clears prescaler and counter
// - changed prescaler value clears prescaler and counter
// - any limit write clears prescaler and counter
// - source bit0 low: binary/decimal table A
// - source bit0 high: table B ratios
// - counter register writes are ignored
// - reset clears everything, limit zero
// - keeps counting and interrupting in wait
// - deep stop keeps only low-power source
// - debug freezes prescaler and counter
// - flag sets on limit-to-zero transition
//
// The strobed register port and the register offsets were chosen for this implementation.
`include "pwc_regs.svh"
module pwc_top
    import pwc_pkg::*;
(
    input  wire logic             clk_sys,      // 200 MHz system clock
    input  wire logic             sys_rst,      // async reset, high
    input  wire logic [`PWC_AW-1:0] addr,       // register address
    input  wire logic [`PWC_DW-1:0] wr_data,    // write data
    input  wire logic             wr_en,        // write strobe
    input  wire logic             rd_en,        // read strobe
    output logic [`PWC_DW-1:0]    rd_data,      // read data, cycle after strobe
    input  wire logic             lpo_clk,      // low_power_oscillator pin
    input  wire logic             ext_ref_clk,  // external_reference_clock pin
    input  wire logic             int_ref_clk,  // internal_reference_clock pin
    input  wire logic             stop_deep,    // deep stop: only low-power source runs
    input  wire logic             debug_active, // background debug freeze
    output logic                  irq           // level interrupt / wake request
);

    // source synchronisers: stage 1 feeds stage 2 only
    logic [2:0] src_s1_r;
    logic [2:0] src_s2_r;
    logic [2:0] src_s3_r;
    logic [2:0] src_rise;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            src_s1_r <= 3'h0;
            src_s2_r <= 3'h0;
            src_s3_r <= 3'h0;
        end else begin
            src_s1_r <= {int_ref_clk, ext_ref_clk, lpo_clk};
            src_s2_r <= src_s1_r;
            src_s3_r <= src_s2_r;
        end
    end

    assign src_rise = src_s2_r & ~src_s3_r;

    // configuration, counter, flag and next-value signals
    pwc_cfg_s         cfg_r;
    logic [7:0]       limit_r;
    logic [7:0]       count_r;
    logic [7:0]       count_nxt;
    logic             flag_r;
    logic             flag_nxt;
    logic [7:0]       rd_nxt;
    logic             irq_nxt;

    // bus decode
    logic wr_status;
    logic wr_count;
    logic wr_limit;
    logic wr_irq_en;
    logic wr_irq_clr;
    logic rd_hit;

    assign wr_status  = wr_en && (addr == `PWC_OFS_STATUS);
    assign wr_count   = wr_en && (addr == `PWC_OFS_COUNT);
    assign wr_limit   = wr_en && (addr == `PWC_OFS_LIMIT);
    assign wr_irq_en  = wr_en && (addr == `PWC_OFS_IRQ_EN);
    assign wr_irq_clr = wr_en && (addr == `PWC_OFS_IRQ_CLR);
    assign rd_hit     = rd_en;

    // new field values from a status write
    logic [1:0] new_lks;
    logic [3:0] new_ps;
    logic       new_ie;
    logic       lks_chg;
    logic       ps_chg;
    logic       cfg_clr;

    assign new_lks = wr_data[`PWC_LKS_HI:`PWC_LKS_LO];
    assign new_ps  = wr_data[`PWC_PS_HI:`PWC_PS_LO];
    assign new_ie  = wr_data[`PWC_IE_BIT];
    assign lks_chg = wr_status && (new_lks != cfg_r.lks);
    assign ps_chg  = wr_status && (new_ps != cfg_r.ps);
    assign cfg_clr = lks_chg || ps_chg || wr_limit;

    // source mux; reference clocks are gated off in deep stop
    logic src_tick;
    logic ref_ok;

    assign ref_ok   = !stop_deep;
    assign src_tick = (cfg_r.lks == 2'h0) ? src_rise[0] :
                      (cfg_r.lks == 2'h1) ? (src_rise[1] && ref_ok) :
                                            (src_rise[2] && ref_ok);

    // prescaler
    logic pre_tick;
    logic cnt_en;

    pwc_prescaler u_pre (
        .clk_sys  (clk_sys),
        .sys_rst  (sys_rst),
        .src_tick (src_tick),
        .cfg      (cfg_r),
        .clear    (cfg_clr),
        .freeze   (debug_active),
        .tick     (pre_tick)
    );

    // a tick already in flight when debug starts is dropped too
    assign cnt_en = pre_tick && !debug_active;

    // counter and match flag
    logic at_limit;
    logic match_evt;
    logic flag_clr;

    assign at_limit  = (count_r == limit_r);
    assign match_evt = cnt_en && at_limit && !cfg_clr;

    // clears win over a coincident tick so software sees a clean restart
    assign count_nxt = cfg_clr  ? `PWC_RST_BYTE :
                       !cnt_en  ? count_r :
                       at_limit ? `PWC_RST_BYTE :
                                  count_r + 8'h01;

    assign flag_clr  = (wr_status && wr_data[`PWC_FLAG_BIT]) ||
                       (wr_irq_clr && wr_data[`PWC_IRQ_EVT_BIT]);
    // set beats clear so a match in the clearing cycle is kept
    assign flag_nxt  = match_evt || (flag_r && !flag_clr);

    // the enable has two aliases; inputs come in as arguments so the assign tracks them all
    function automatic logic pick_ie(input logic cur,
                                     input logic st_wr,
                                     input logic st_val,
                                     input logic en_wr,
                                     input logic en_val);
        logic v;
        v = cur;
        if (st_wr) begin
            v = st_val;
        end
        if (en_wr) begin
            v = en_val;
        end
        return v;
    endfunction

    logic ie_nxt;

    assign ie_nxt  = pick_ie(cfg_r.ie, wr_status, new_ie, wr_irq_en, wr_data[`PWC_IRQ_EVT_BIT]);
    // interrupt is not masked by any low-power state so it can wake the core
    assign irq_nxt = flag_nxt && ie_nxt;

    // read mux
    logic [7:0] status_view;
    logic [7:0] irq_stat_view;
    logic [7:0] irq_en_view;

    assign status_view   = {flag_r, cfg_r.lks, cfg_r.ie, cfg_r.ps};
    assign irq_stat_view = {7'h00, flag_r};
    assign irq_en_view   = {7'h00, cfg_r.ie};

    assign rd_nxt = !rd_hit                      ? `PWC_RST_BYTE :
                    (addr == `PWC_OFS_STATUS)    ? status_view :
                    (addr == `PWC_OFS_COUNT)     ? count_r :
                    (addr == `PWC_OFS_LIMIT)     ? limit_r :
                    (addr == `PWC_OFS_IRQ_STAT)  ? irq_stat_view :
                    (addr == `PWC_OFS_IRQ_EN)    ? irq_en_view :
                                                   `PWC_RST_BYTE;

    // state registers
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_r.lks <= `PWC_RST_LKS;
            cfg_r.ps  <= `PWC_RST_PS;
            cfg_r.ie  <= 1'b0;
            limit_r   <= `PWC_RST_LIMIT;
            count_r   <= `PWC_RST_BYTE;
            flag_r    <= 1'b0;
        end else begin
            if (wr_status) begin
                cfg_r.lks <= new_lks;
                cfg_r.ps  <= new_ps;
            end
            cfg_r.ie <= ie_nxt;
            if (wr_limit) begin
                limit_r <= wr_data;
            end
            count_r <= count_nxt;
            flag_r  <= flag_nxt;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            rd_data <= `PWC_RST_BYTE;
            irq     <= 1'b0;
        end else begin
            rd_data <= rd_nxt;
            irq     <= irq_nxt;
        end
    end

    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    count_step_a: assert property (
        cnt_en && !at_limit && !cfg_clr |=> count_r == $past(count_r) + 8'h01)
        else $error("counter did not advance on tick");

    count_wrap_a: assert property (
        cnt_en && at_limit && !cfg_clr |=> count_r == 8'h00 && flag_r)
        else $error("counter did not wrap with flag at limit");

    limit_zero_a: assert property (
        cnt_en && limit_r == 8'h00 && !cfg_clr |=> flag_r)
        else $error("zero limit tick did not set flag");

    flag_clear_a: assert property (
        wr_status && wr_data[`PWC_FLAG_BIT] && !match_evt |=> !flag_r && !irq)
        else $error("flag clear write failed");

    flag_hold_a: assert property (
        flag_r && !flag_clr |=> flag_r)
        else $error("flag dropped without clear");

    irq_follow_a: assert property (
        flag_r && cfg_r.ie && !flag_clr && !wr_status && !wr_irq_en |=> irq)
        else $error("interrupt missing with flag and enable");

    irq_quiet_a: assert property (
        !flag_r |-> !irq || $past(flag_r))
        else $error("interrupt without flag");

    src_clear_a: assert property (
        lks_chg || ps_chg |=> count_r == 8'h00 && !pre_tick)
        else $error("config change did not clear counters");

    limit_write_a: assert property (
        wr_limit |=> count_r == 8'h00 && limit_r == $past(wr_data))
        else $error("limit write did not clear and store");

    prescale_off_a: assert property (
        cfg_r.ps == `PWC_PS_OFF && $past(cfg_r.ps) == `PWC_PS_OFF |-> !pre_tick)
        else $error("prescaler ran while off");

    count_write_a: assert property (
        wr_count && !cnt_en |=> count_r == $past(count_r))
        else $error("count write changed counter");

    deep_stop_a: assert property (
        stop_deep && cfg_r.lks != 2'h0 |-> !src_tick)
        else $error("reference source ran in deep stop");

    debug_freeze_a: assert property (
        debug_active && !cfg_clr |=> count_r == $past(count_r))
        else $error("counter moved in debug");

    read_count_a: assert property (
        rd_en && addr == `PWC_OFS_COUNT |=> rd_data == $past(count_r))
        else $error("count read mismatch");

    // source selection, checked per code; the low-power source must survive deep stop
    lpo_pick_a: assert property (
        cfg_r.lks == 2'h0 |-> src_tick == src_rise[0])
        else $error("low-power source not selected");

    ext_pick_a: assert property (
        cfg_r.lks == 2'h1 && !stop_deep |-> src_tick == src_rise[1])
        else $error("external source not selected");

    int_pick_a: assert property (
        cfg_r.lks[1] && !stop_deep |-> src_tick == src_rise[2])
        else $error("internal source not selected");

    status_store_a: assert property (
        wr_status |=> cfg_r.lks == $past(new_lks) && cfg_r.ps == $past(new_ps) &&
                      cfg_r.ie == $past(new_ie))
        else $error("status write not stored");

    same_write_a: assert property (
        wr_status && !lks_chg && !ps_chg && !cnt_en |=> count_r == $past(count_r))
        else $error("same-value write cleared counter");

    prescale_src_a: assert property (
        pre_tick |-> $past(src_tick) && !$past(cfg_clr))
        else $error("prescaler tick without source edge");

    div_one_a: assert property (
        src_tick && cfg_r.ps == 4'h8 && !cfg_r.lks[0] && !debug_active && !cfg_clr
        |=> pre_tick)
        else $error("divide by one missed a source edge");

    reset_vals_a: assert property (
        $fell(sys_rst) |-> count_r == 8'h00 && limit_r == 8'h00 && !flag_r &&
                           cfg_r == '0 && !irq && rd_data == 8'h00)
        else $error("state not cleared by reset");

    irq_level_a: assert property (
        irq == (flag_r && cfg_r.ie))
        else $error("interrupt level disagrees with flag and enable");

    flag_source_a: assert property (
        !flag_r && !(cnt_en && at_limit) |=> !flag_r)
        else $error("flag set without limit-to-zero step");

    flag_set_a: assert property (
        match_evt |=> flag_r)
        else $error("match did not set flag");

    irq_clear_a: assert property (
        wr_irq_clr && wr_data[`PWC_IRQ_EVT_BIT] && !match_evt |=> !flag_r && !irq)
        else $error("interrupt clear write failed");

    ie_alias_a: assert property (
        wr_irq_en |=> cfg_r.ie == $past(wr_data[`PWC_IRQ_EVT_BIT]))
        else $error("enable alias write not stored");

    tick_single_a: assert property (
        pre_tick |=> !pre_tick)
        else $error("count enable longer than one cycle");

    debug_tick_a: assert property (
        debug_active |=> !pre_tick)
        else $error("prescaler ticked in debug");

    wrap_c:     cover property (cnt_en && at_limit && limit_r != 8'h00);
    zero_lim_c: cover property (cnt_en && limit_r == 8'h00 ##1 flag_r);
    stop_c:     cover property (stop_deep && src_rise[2]);
    irq_c:      cover property (!irq ##1 irq);
    freeze_c:   cover property (debug_active && pre_tick);

endmodule

// ---- shared/pwc_regs.svh ----
// register offsets, field positions, reset values and divide table of the wakeup counter
`ifndef PWC_REGS_SVH
`define PWC_REGS_SVH

`define PWC_AW            4
`define PWC_DW            8
`define PWC_DIVW          18

`define PWC_OFS_STATUS    4'h0
`define PWC_OFS_COUNT     4'h1
`define PWC_OFS_LIMIT     4'h2
`define PWC_OFS_IRQ_STAT  4'h3
`define PWC_OFS_IRQ_EN    4'h4
`define PWC_OFS_IRQ_CLR   4'h5

`define PWC_FLAG_BIT      7
`define PWC_LKS_HI        6
`define PWC_LKS_LO        5
`define PWC_IE_BIT        4
`define PWC_PS_HI         3
`define PWC_PS_LO         0
`define PWC_IRQ_EVT_BIT   0

`define PWC_RST_BYTE      8'h00
`define PWC_RST_LIMIT     8'h00
`define PWC_RST_LKS       2'h0
`define PWC_RST_PS        4'h0
`define PWC_PS_OFF        4'h0
`define PWC_ONE           18'h00001
`define PWC_DIV_OFF       18'h00000

`define PWC_DA_1          18'h00008
`define PWC_DA_2          18'h00020
`define PWC_DA_3          18'h00040
`define PWC_DA_4          18'h00080
`define PWC_DA_5          18'h00100
`define PWC_DA_6          18'h00200
`define PWC_DA_7          18'h00400
`define PWC_DA_8          18'h00001
`define PWC_DA_9          18'h00002
`define PWC_DA_10         18'h00004
`define PWC_DA_11         18'h0000A
`define PWC_DA_12         18'h00010
`define PWC_DA_13         18'h00064
`define PWC_DA_14         18'h001F4
`define PWC_DA_15         18'h003E8

`define PWC_DB_1          18'h00400
`define PWC_DB_2          18'h00800
`define PWC_DB_3          18'h01000
`define PWC_DB_4          18'h02000
`define PWC_DB_5          18'h04000
`define PWC_DB_6          18'h08000
`define PWC_DB_7          18'h10000
`define PWC_DB_8          18'h003E8
`define PWC_DB_9          18'h007D0
`define PWC_DB_10         18'h01388
`define PWC_DB_11         18'h02710
`define PWC_DB_12         18'h04E20
`define PWC_DB_13         18'h0C350
`define PWC_DB_14         18'h186A0
`define PWC_DB_15         18'h30D40

`endif

// ---- shared/pwc_pkg.sv ----
// types and divide-ratio decode shared by the wakeup counter modules
`include "pwc_regs.svh"
package pwc_pkg;

    typedef struct packed {
        logic [1:0] lks;
        logic       ie;
        logic [3:0] ps;
    } pwc_cfg_s;

    typedef logic [`PWC_DIVW-1:0] pwc_div_t;

    // zero means the prescaler is off
    function automatic pwc_div_t pwc_divisor(input logic lks0, input logic [3:0] ps);
        pwc_div_t d;
        d = `PWC_DIV_OFF;
        unique case ({lks0, ps})
            5'h01: d = `PWC_DA_1;
            5'h02: d = `PWC_DA_2;
            5'h03: d = `PWC_DA_3;
            5'h04: d = `PWC_DA_4;
            5'h05: d = `PWC_DA_5;
            5'h06: d = `PWC_DA_6;
            5'h07: d = `PWC_DA_7;
            5'h08: d = `PWC_DA_8;
            5'h09: d = `PWC_DA_9;
            5'h0A: d = `PWC_DA_10;
            5'h0B: d = `PWC_DA_11;
            5'h0C: d = `PWC_DA_12;
            5'h0D: d = `PWC_DA_13;
            5'h0E: d = `PWC_DA_14;
            5'h0F: d = `PWC_DA_15;
            5'h11: d = `PWC_DB_1;
            5'h12: d = `PWC_DB_2;
            5'h13: d = `PWC_DB_3;
            5'h14: d = `PWC_DB_4;
            5'h15: d = `PWC_DB_5;
            5'h16: d = `PWC_DB_6;
            5'h17: d = `PWC_DB_7;
            5'h18: d = `PWC_DB_8;
            5'h19: d = `PWC_DB_9;
            5'h1A: d = `PWC_DB_10;
            5'h1B: d = `PWC_DB_11;
            5'h1C: d = `PWC_DB_12;
            5'h1D: d = `PWC_DB_13;
            5'h1E: d = `PWC_DB_14;
            5'h1F: d = `PWC_DB_15;
            default: d = `PWC_DIV_OFF;
        endcase
        return d;
    endfunction

endpackage

// ---- design/pwc_prescaler.sv ----
// prescaler: divides source-clock edge ticks into one-cycle count enables
`include "pwc_regs.svh"
module pwc_prescaler
    import pwc_pkg::*;
(
    input  wire logic     clk_sys,   // system clock
    input  wire logic     sys_rst,   // async reset, high
    input  wire logic     src_tick,  // one pulse per source rising edge
    input  wire pwc_cfg_s cfg,       // current configuration
    input  wire logic     clear,     // restart from zero
    input  wire logic     freeze,    // hold during debug
    output logic          tick       // one-cycle prescaler output
);

    pwc_div_t div;
    pwc_div_t cnt_r;
    pwc_div_t cnt_nxt;
    logic     tick_nxt;
    logic     run;
    logic     last;

    assign div  = pwc_divisor(cfg.lks[0], cfg.ps);
    assign run  = src_tick && !freeze && (div != `PWC_DIV_OFF);
    assign last = (cnt_r == div - `PWC_ONE);

    assign cnt_nxt  = clear ? `PWC_DIV_OFF :
                      !run  ? cnt_r :
                      last  ? `PWC_DIV_OFF : cnt_r + `PWC_ONE;
    assign tick_nxt = !clear && run && last;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_r <= `PWC_DIV_OFF;
            tick  <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            tick  <= tick_nxt;
        end
    end

endmodule

// ---- verif/tb_pwc_top.sv ----
// self-checking bench for the periodic wakeup counter, driven over its register port
`include "pwc_regs.svh"
module tb_pwc_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic                   clk_sys;
    logic                   sys_rst;
    logic [`PWC_AW-1:0]     addr;
    logic [`PWC_DW-1:0]     wr_data;
    logic                   wr_en;
    logic                   rd_en;
    logic [`PWC_DW-1:0]     rd_data;
    logic [2:0]             src;
    logic                   stop_deep;
    logic                   debug_active;
    logic                   irq;
    int                     errors;
    int                     n_tests;

    pwc_top u_pwc_top (
        .clk_sys      (clk_sys),
        .sys_rst      (sys_rst),
        .addr         (addr),
        .wr_data      (wr_data),
        .wr_en        (wr_en),
        .rd_en        (rd_en),
        .rd_data      (rd_data),
        .lpo_clk      (src[0]),
        .ext_ref_clk  (src[1]),
        .int_ref_clk  (src[2]),
        .stop_deep    (stop_deep),
        .debug_active (debug_active),
        .irq          (irq)
    );

    initial begin
        clk_sys = 1'b0;
        sys_rst = 1'b1;
        addr = 4'h0;
        wr_data = 8'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
        src = 3'h0;
        stop_deep = 1'b0;
        debug_active = 1'b0;
        errors = 0;
        n_tests = 0;
    end

    always #2.5 clk_sys = ~clk_sys;

    task automatic end_sim();
        $display("checks %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("FAIL at %0t: byte %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("FAIL at %0t: irq %b, expected %b", $time, got, exp);
        end
    endtask

    task automatic do_reset();
        sys_rst <= 1'b1;
        repeat (20) @(posedge clk_sys);
        sys_rst <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clk_sys);
        wr_en <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk_sys);
        rd_en <= 1'b0;
        #1;
        chk8(rd_data, exp);
    endtask

    // each source edge is held well over two system cycles so the synchroniser sees it
    task automatic pulses(input int sel, input int n);
        repeat (n) begin
            @(posedge clk_sys);
            src[sel] <= 1'b1;
            repeat (3) @(posedge clk_sys);
            src[sel] <= 1'b0;
            repeat (4) @(posedge clk_sys);
        end
    endtask

    task automatic t_reset();
        rd_chk(`PWC_OFS_STATUS, 8'h00);
        rd_chk(`PWC_OFS_COUNT, 8'h00);
        rd_chk(`PWC_OFS_LIMIT, 8'h00);
        chk1(irq, 1'b0);
        pulses(0, 3);
        rd_chk(`PWC_OFS_COUNT, 8'h00);
    endtask

    task automatic chk_div(input logic [1:0] lks, input logic [3:0] ps, input int sel,
                           input int n);
        wr(`PWC_OFS_STATUS, {1'b0, lks, 1'b0, ps});
        pulses(sel, n - 1);
        rd_chk(`PWC_OFS_COUNT, 8'h00);
        pulses(sel, 1);
        rd_chk(`PWC_OFS_COUNT, 8'h01);
    endtask

    task automatic t_divide();
        wr(`PWC_OFS_LIMIT, 8'hFF);
        chk_div(2'h0, 4'h8, 0, 1);
        chk_div(2'h0, 4'h9, 0, 2);
        chk_div(2'h0, 4'hA, 0, 4);
        chk_div(2'h0, 4'hB, 0, 10);
        chk_div(2'h0, 4'hC, 0, 16);
        chk_div(2'h0, 4'h1, 0, 8);
        chk_div(2'h2, 4'h8, 2, 1);
        chk_div(2'h1, 4'h8, 1, 1000);
        chk_div(2'h3, 4'h8, 2, 1000);
    endtask

    task automatic t_wrap();
        wr(`PWC_OFS_LIMIT, 8'h03);
        wr(`PWC_OFS_STATUS, 8'h08);
        pulses(0, 3);
        rd_chk(`PWC_OFS_COUNT, 8'h03);
        rd_chk(`PWC_OFS_STATUS, 8'h08);
        pulses(0, 1);
        rd_chk(`PWC_OFS_COUNT, 8'h00);
        rd_chk(`PWC_OFS_STATUS, 8'h88);
        wr(`PWC_OFS_COUNT, 8'h55);
        rd_chk(`PWC_OFS_COUNT, 8'h00);
        pulses(0, 1);
        wr(`PWC_OFS_STATUS, 8'h08);
        rd_chk(`PWC_OFS_STATUS, 8'h88);
        wr(`PWC_OFS_STATUS, 8'h88);
        rd_chk(`PWC_OFS_STATUS, 8'h08);
        rd_chk(`PWC_OFS_COUNT, 8'h01);
    endtask

    task automatic t_clears();
        pulses(0, 2);
        wr(`PWC_OFS_STATUS, 8'h48);
        rd_chk(`PWC_OFS_COUNT, 8'h00);
        pulses(2, 2);
        rd_chk(`PWC_OFS_COUNT, 8'h02);
        wr(`PWC_OFS_STATUS, 8'h49);
        rd_chk(`PWC_OFS_COUNT, 8'h00);
        pulses(2, 3);
        rd_chk(`PWC_OFS_COUNT, 8'h01);
        wr(`PWC_OFS_LIMIT, 8'h03);
        rd_chk(`PWC_OFS_COUNT, 8'h00);
        pulses(2, 1);
        rd_chk(`PWC_OFS_COUNT, 8'h00);
        pulses(2, 1);
        rd_chk(`PWC_OFS_COUNT, 8'h01);
    endtask

    task automatic t_irq();
        wr(`PWC_OFS_LIMIT, 8'h00);
        wr(`PWC_OFS_STATUS, 8'h18);
        pulses(0, 1);
        rd_chk(`PWC_OFS_STATUS, 8'h98);
        chk1(irq, 1'b1);
        rd_chk(`PWC_OFS_IRQ_STAT, 8'h01);
        wr(`PWC_OFS_IRQ_CLR, 8'h01);
        rd_chk(`PWC_OFS_STATUS, 8'h18);
        chk1(irq, 1'b0);
        pulses(0, 1);
        rd_chk(`PWC_OFS_STATUS, 8'h98);
        wr(`PWC_OFS_IRQ_EN, 8'h00);
        rd_chk(`PWC_OFS_STATUS, 8'h88);
        chk1(irq, 1'b0);
        wr(`PWC_OFS_IRQ_EN, 8'h01);
        rd_chk(`PWC_OFS_IRQ_EN, 8'h01);
        chk1(irq, 1'b1);
        wr(`PWC_OFS_STATUS, 8'h98);
        rd_chk(4'hF, 8'h00);
        chk1(irq, 1'b0);
    endtask

    task automatic t_modes();
        wr(`PWC_OFS_STATUS, 8'h48);
        wr(`PWC_OFS_LIMIT, 8'hFF);
        stop_deep <= 1'b1;
        pulses(2, 2);
        rd_chk(`PWC_OFS_COUNT, 8'h00);
        wr(`PWC_OFS_STATUS, 8'h08);
        pulses(0, 2);
        rd_chk(`PWC_OFS_COUNT, 8'h02);
        stop_deep <= 1'b0;
        debug_active <= 1'b1;
        pulses(0, 3);
        rd_chk(`PWC_OFS_COUNT, 8'h02);
        debug_active <= 1'b0;
        pulses(0, 1);
        rd_chk(`PWC_OFS_COUNT, 8'h03);
        wr(`PWC_OFS_STATUS, 8'h5A);
        do_reset();
        rd_chk(`PWC_OFS_STATUS, 8'h00);
        rd_chk(`PWC_OFS_LIMIT, 8'h00);
        rd_chk(`PWC_OFS_COUNT, 8'h00);
    endtask

    // longest path is two divide-by-1000 runs of eight cycles per edge
    initial begin
        repeat (60000) @(posedge clk_sys);
        errors++;
        $display("FAIL at %0t: watchdog expired", $time);
        end_sim();
    end

    initial begin
        do_reset();
        t_reset();
        t_wrap();
        t_clears();
        t_irq();
        t_modes();
        t_divide();
        end_sim();
    end
endmodule
